// >>> bench/safety_partner.sv
// Switches, test-pulsing contacts and output readback wired to the safety I/O block.
`timescale 1ns/1ns
module safety_partner (
    input  wire logic [5:0] press_a,
    input  wire logic [5:0] press_b,
    input  wire logic [5:0] tested,
    input  wire logic       short_in,
    input  wire logic [3:0] flip,
    input  wire logic [3:0] cyc_out,
    input  wire logic [3:0] safe_out,
    output logic      [5:0] safe_in_a_n,
    output logic      [5:0] safe_in_b_n,
    output logic      [3:0] out_fb
);
    // An open contact removes the voltage; a closed tested contact returns its group clock.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            safe_in_a_n[i] = press_a[i] ? 1'b0 : (!tested[i] | short_in | cyc_out[(i / 3) * 2]);
            safe_in_b_n[i] = press_b[i] ? 1'b0 : (!tested[i] | short_in | cyc_out[(i / 3) * 2 + 1]);
        end
    end
    // A set flip bit models the output line shorted to another potential.
    assign out_fb = safe_out ^ flip;
endmodule : safety_partner

// >>> bench/tb_safety_io_interface.sv
// Self-checking bench for the safety I/O interface.
`timescale 1ns/1ns
module tb_safety_io_interface;
    logic                     ref_clk, rst, sh;
    safety_io_pkg::axil_req_t req;
    safety_io_pkg::axil_rsp_t rsp;
    logic [5:0]               pa, pb, tst, ia, ib;
    logic [1:0]               sa, sb, ca, cb, oa, ob, inh, r, cl;
    logic [15:0]              act, rq;
    logic [11:0]              pwm, pwo;
    logic [3:0]               fl, fb, so, cyc;
    logic                     flt;
    logic [31:0]              d, m;
    logic [31:0]              reg_m[int];
    int                       fail_count = 0, check_count = 0, cyc_n = 0, seed, i, s, k;
    int                       q[$];

    safety_io_interface uut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .bus_req(req), .bus_rsp(rsp),
        .safe_in_a_n(ia), .safe_in_b_n(ib), .sto_in_a_n(sa), .sto_in_b_n(sb), .chain_in_a_n(ca),
        .chain_in_b_n(cb), .sfn_active(act), .out_fb(fb), .pwm_in(pwm), .chain_out_a_n(oa),
        .chain_out_b_n(ob), .safe_out(so), .cyc_out(cyc), .sfn_request(rq), .pulse_inhibit(inh),
        .pwm_out(pwo), .fault(flt));
    safety_partner prt (.press_a(pa), .press_b(pb), .tested(tst), .short_in(sh), .flip(fl),
        .cyc_out(cyc), .safe_out(so), .safe_in_a_n(ia), .safe_in_b_n(ib), .out_fb(fb));

    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string t);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t reg %s got %h exp %h", $time, t, g, e);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e, input string t);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t pin %s got %h exp %h", $time, t, g, e);
        end
    endtask : chk_pin

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, b;
        aw = 1;
        w = 1;
        b = 0;
        @(posedge ref_clk);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!b) begin
            @(negedge ref_clk);
            b = rsp.bvalid;
            rs = rsp.bresp;
            if (rsp.awready) aw = 0;
            if (rsp.wready) w = 0;
            @(posedge ref_clk);
            req.awvalid <= aw;
            req.wvalid <= w;
            req.bready <= !b;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, rv;
        ar = 1;
        rv = 0;
        @(posedge ref_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        while (!rv) begin
            @(negedge ref_clk);
            rv = rsp.rvalid;
            v = rsp.rdata;
            rs = rsp.rresp;
            if (rsp.arready) ar = 0;
            @(posedge ref_clk);
            req.arvalid <= ar;
            req.rready <= !rv;
        end
    endtask : rd

    task automatic cfg(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
        reg_m[a] = v;
        chk_reg(32'(r), 32'(safety_io_pkg::RESP_OKAY), "bresp");
    endtask : cfg

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wt

    task automatic clr(input logic [31:0] e);
        wr(8'h20, 32'h7, r);
        rd(8'h20, d, r);
        chk_reg(d, e, "fault w1c");
    endtask : clr

    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            fail_count++;
            end_sim();
        end
    end

    always @(negedge ref_clk) begin
        if (cyc[1:0] !== cl) q.push_back(cyc_n);
        cl <= cyc[1:0];
        if (!rst) chk_pin(cyc[3:2], cyc[1:0], "group phase");
    end

    initial begin
        seed = 32'hb5b9;
        req = '0;
        rst = 1;
        {pa, pb, tst, sh, fl, act, pwm} = '0;
        {sa, sb, ca, cb} = 8'hff;
        for (i = 0; i <= 32; i += 4) reg_m[i] = 0;
        reg_m[8'h14] = safety_io_pkg::RST_OUTCFG;
        reg_m[8'h18] = safety_io_pkg::RST_DISC;
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        for (i = 0; i <= 32; i += 4) begin
            rd(8'(i), d, r);
            if (i != 28) chk_reg(d, reg_m[i], "reset value");
        end
        wr(8'h40, 32'h1, r);
        chk_reg(32'(r), 32'(safety_io_pkg::RESP_SLVERR), "unmapped wr");
        rd(8'h40, d, r);
        chk_reg(32'(r), 32'(safety_io_pkg::RESP_SLVERR), "unmapped rd");
        $display("test registers done");
        @(posedge ref_clk);
        pwm <= 12'($random(seed));
        sa <= 2'b10;
        sb <= 2'b10;
        wt(2);
        chk_pin(inh, 2'b01, "inhibit");
        chk_pin(rq[0], 1, "torque off request");
        chk_pin(pwo, {pwm[11:6], 6'h0}, "pulses blocked");
        @(posedge ref_clk);
        sa <= 2'b11;
        sb <= 2'b11;
        wt(2);
        chk_pin(inh, 2'b00, "inhibit off");
        chk_pin(pwo, pwm, "pulses pass");
        $display("test torque off done");
        d = 0;
        for (i = 0; i < 6; i++) d |= 32'(i + 1) << (3 * i);
        cfg(8'h08, d);
        for (s = 0; s < 2; s++) begin
            cfg(8'h00, 32'(s));
            for (i = 3 * s; i < 6; i++) begin
                k = (i > 2 && s == 0) ? 9 + i : i + 1;
                @(posedge ref_clk);
                pa[i] <= 1'b1;
                pb[i] <= 1'b1;
                wt(2);
                chk_pin(rq[k], 1, "input request");
                rd(8'h1c, d, r);
                chk_reg(d[i], 1, "input status");
                @(posedge ref_clk);
                pa[i] <= 1'b0;
                pb[i] <= 1'b0;
                wt(2);
                chk_pin(rq[k], 0, "input idle");
            end
        end
        cfg(8'h00, 0);
        cfg(8'h04, 32'h1);
        for (k = 10; k <= 70; k += 60) begin
            @(posedge ref_clk);
            pa[0] <= 1'b1;
            pb[0] <= 1'b1;
            wt(k < safety_io_pkg::FILT_CYC ? k : safety_io_pkg::FILT_CYC + 3);
            chk_pin(rq[1], k > safety_io_pkg::FILT_CYC, "filtered input");
            @(posedge ref_clk);
            pa[0] <= 1'b0;
            pb[0] <= 1'b0;
            wt(safety_io_pkg::FILT_CYC + 3);
        end
        cfg(8'h04, 0);
        $display("test inputs done");
        cfg(8'h0c, 32'h50);
        @(posedge ref_clk);
        ca <= 2'b10;
        cb <= 2'b10;
        wt(2);
        chk_pin(rq[5], 0, "chain disabled");
        cfg(8'h0c, 32'h51);
        wt(2);
        chk_pin(rq[5], 1, "chain enabled");
        @(posedge ref_clk);
        ca <= 2'b11;
        cb <= 2'b11;
        for (i = 0; i < 8; i++) begin
            m = 32'($random(seed)) & 32'h0000_ffff;
            cfg(8'h10, m);
            @(posedge ref_clk);
            act <= 16'($random(seed));
            wt(2);
            chk_pin(oa[0], ~|(act[7:0] & m[7:0]), "chain out 0");
            chk_pin(ob, oa, "chain out b");
            chk_pin(oa[1], ~|(act[15:8] & m[15:8]), "chain out 1");
        end
        $display("test chain done");
        cfg(8'h14, 32'h1010_1011);
        @(posedge ref_clk);
        act <= 16'h0002;
        wt(2);
        chk_pin(so[0], 0, "inverted output");
        cfg(8'h14, 32'h1010_1001);
        wt(2);
        chk_pin(so[0], 1, "polarity");
        @(posedge ref_clk);
        act <= 16'h0000;
        cfg(8'h14, safety_io_pkg::RST_OUTCFG);
        cfg(8'h18, 32'd20);
        @(posedge ref_clk);
        pa[2] <= 1'b1;
        wt(15);
        chk_pin(flt, 0, "no discrepancy yet");
        wt(15);
        chk_pin(flt, 1, "discrepancy");
        chk_pin(inh, 2'b11, "fault inhibit");
        @(posedge ref_clk);
        pa[2] <= 1'b0;
        clr(0);
        @(posedge ref_clk);
        fl <= 4'h1;
        wt(2);
        chk_pin(flt, 1, "readback fault");
        clr(32'h4);
        @(posedge ref_clk);
        fl <= 4'h0;
        clr(0);
        $display("test faults done");
        cfg(8'h18, 32'hffff);
        tst <= 6'h02;
        cfg(8'h04, 32'h0200);
        q.delete();
        wt(4200);
        chk_pin(q.size() >= 4, 1, "clocks run");
        for (i = 1; i < q.size(); i++) chk_pin(q[i] - q[i - 1], safety_io_pkg::QUARTER_CYC, "quarter");
        chk_pin(flt, 0, "clock returned");
        @(posedge ref_clk);
        sh <= 1'b1;
        wt(4200);
        chk_pin(flt, 1, "crossfault");
        @(posedge ref_clk);
        sh <= 1'b0;
        clr(0);
        $display("test cycle outputs done");
        end_sim();
    end
endmodule : tb_safety_io_interface

// >>> hw/safety_io_interface.sv
// Safety I/O evaluation, test clocks, chain and safe outputs behind an AXI4-Lite slave.
//
// Contract
// - A missing voltage on any safe input counts as active and triggers its function.
// - Six dual-channel low-active safe inputs, each mapped to one safety function.
// - In single-axis mode all safe inputs may serve axis one.
// - Optional filter keeps short sensor test pulses from toggling the input state.
// - Test clocks from cycle outputs must return on tested inputs, else crossfault.
// - Two dual-channel low-active torque-off inputs assert pulse inhibit per axis.
// - Pulse inhibit blocks switching pulses and leaves motor supply untouched.
// - Each chain input maps to one function and is individually enabled.
// - Two dual-channel chain outputs forward active functions to the next module.
// - A chain output goes to zero volts when any selected function is active.
// - Several functions may be selected per chain output, combined by OR.
// - Four safe outputs, each freely assigned to an axis and function.
// - In single-axis mode all safe outputs may serve axis one.
// - Per-output polarity; inverted low-active is the default.
// - Diagnostics detect safe output lines shorted to other potentials.
// - Four cycle outputs drive test clock patterns.
// - A clocks of both groups share phase; B clocks are a quarter period off.
// - Faults are told apart only by A against B; A-to-A shorts go unseen.
`timescale 1ns/1ns
module safety_io_interface (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire safety_io_pkg::axil_req_t  bus_req,
    output safety_io_pkg::axil_rsp_t       bus_rsp,
    input  wire logic [5:0]                safe_in_a_n,
    input  wire logic [5:0]                safe_in_b_n,
    input  wire logic [1:0]                sto_in_a_n,
    input  wire logic [1:0]                sto_in_b_n,
    input  wire logic [1:0]                chain_in_a_n,
    input  wire logic [1:0]                chain_in_b_n,
    input  wire logic [15:0]               sfn_active,
    input  wire logic [3:0]                out_fb,
    input  wire logic [11:0]               pwm_in,
    output logic      [1:0]                chain_out_a_n,
    output logic      [1:0]                chain_out_b_n,
    output logic      [3:0]                safe_out,
    output logic      [3:0]                cyc_out,
    output logic      [15:0]               sfn_request,
    output logic      [1:0]                pulse_inhibit,
    output logic      [11:0]               pwm_out,
    output logic                           fault
);
    typedef struct packed {
        logic                    awg;
        logic                    wg;
        logic [7:0]              aw_a;
        logic [31:0]             wd;
        logic [3:0]              ws;
        logic                    bv;
        logic [1:0]              bresp;
        logic                    rv;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [31:0]             ctrl;
        logic [31:0]             incfg;
        logic [31:0]             inmap;
        logic [31:0]             chcfg;
        logic [31:0]             chout;
        logic [31:0]             outcfg;
        logic [31:0]             disc;
        logic [2:0]              cause;
        logic [1:0]              ph;
        logic [9:0]              qcnt;
        logic [3:0]              cyc;
        logic [5:0]              eva;
        logic [5:0]              evb;
        logic [5:0][7:0]         fcnt;
        logic [5:0]              act;
        logic [9:0][15:0]        dcnt;
        logic [15:0]             req;
        logic [1:0]              inh;
        logic [1:0]              chn;
        logic [3:0]              sout;
        logic [11:0]             pwm;
    } state_t;

    state_t q;
    state_t d;

    logic        aw_ok;
    logic        w_ok;
    logic        ar_ok;
    logic        do_wr;
    logic [7:0]  wa;
    logic [31:0] wdat;
    logic [3:0]  wst;
    logic [2:0]  clr;
    logic        tick;
    logic        single;
    logic        raw;
    logic        ax;
    logic        xf_in;
    logic        xd;
    logic        xo;
    logic        flt;
    logic [15:0] rq;
    logic [1:0]  inh;
    logic [9:0]  da;
    logic [9:0]  db;
    logic [7:0]  o;

    function automatic logic [31:0] wr(input logic [31:0] old, input logic [31:0] val,
                                       input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                r[8*k +: 8] = val[8*k +: 8];
            end
        end
        return r & mask;
    endfunction : wr

    always_comb begin
        d = q;
        raw = 1'b0;
        ax = 1'b0;
        o = '0;
        single = q.ctrl[safety_io_pkg::SINGLE_BIT];
        aw_ok = bus_req.awvalid && !q.awg && !q.bv;
        w_ok = bus_req.wvalid && !q.wg && !q.bv;
        ar_ok = bus_req.arvalid && !q.rv;
        do_wr = (q.awg || aw_ok) && (q.wg || w_ok);
        wa = q.awg ? q.aw_a : bus_req.awaddr;
        wdat = q.wg ? q.wd : bus_req.wdata;
        wst = q.wg ? q.ws : bus_req.wstrb;
        clr = '0;
        if (q.bv && bus_req.bready) begin
            d.bv = 1'b0;
        end
        if (aw_ok) begin
            d.awg = 1'b1;
            d.aw_a = bus_req.awaddr;
        end
        if (w_ok) begin
            d.wg = 1'b1;
            d.wd = bus_req.wdata;
            d.ws = bus_req.wstrb;
        end
        // Address and data may arrive in either order; the write fires in the cycle the second of them is accepted.
        if (do_wr) begin
            d.awg = 1'b0;
            d.wg = 1'b0;
            d.bv = 1'b1;
            d.bresp = safety_io_pkg::RESP_OKAY;
            if (wa == safety_io_pkg::OFS_CTRL) begin
                d.ctrl = wr(q.ctrl, wdat, wst, safety_io_pkg::MASK_CTRL);
            end else if (wa == safety_io_pkg::OFS_INCFG) begin
                d.incfg = wr(q.incfg, wdat, wst, safety_io_pkg::MASK_INCFG);
            end else if (wa == safety_io_pkg::OFS_INMAP) begin
                d.inmap = wr(q.inmap, wdat, wst, safety_io_pkg::MASK_INMAP);
            end else if (wa == safety_io_pkg::OFS_CHCFG) begin
                d.chcfg = wr(q.chcfg, wdat, wst, safety_io_pkg::MASK_CHCFG);
            end else if (wa == safety_io_pkg::OFS_CHOUT) begin
                d.chout = wr(q.chout, wdat, wst, safety_io_pkg::MASK_CHOUT);
            end else if (wa == safety_io_pkg::OFS_OUTCFG) begin
                d.outcfg = wr(q.outcfg, wdat, wst, safety_io_pkg::MASK_OUTCFG);
            end else if (wa == safety_io_pkg::OFS_DISC) begin
                d.disc = wr(q.disc, wdat, wst, safety_io_pkg::MASK_DISC);
            end else if (wa == safety_io_pkg::OFS_FAULT) begin
                clr = 3'(wr(32'h0, wdat, wst, safety_io_pkg::MASK_FAULT));
            end else if (wa != safety_io_pkg::OFS_STATUS) begin
                d.bresp = safety_io_pkg::RESP_SLVERR;
            end
        end
        if (q.rv && bus_req.rready) begin
            d.rv = 1'b0;
        end
        if (ar_ok) begin
            d.rv = 1'b1;
            d.rresp = safety_io_pkg::RESP_OKAY;
            d.rdata = '0;
            if (bus_req.araddr == safety_io_pkg::OFS_CTRL) begin
                d.rdata = q.ctrl;
            end else if (bus_req.araddr == safety_io_pkg::OFS_INCFG) begin
                d.rdata = q.incfg;
            end else if (bus_req.araddr == safety_io_pkg::OFS_INMAP) begin
                d.rdata = q.inmap;
            end else if (bus_req.araddr == safety_io_pkg::OFS_CHCFG) begin
                d.rdata = q.chcfg;
            end else if (bus_req.araddr == safety_io_pkg::OFS_CHOUT) begin
                d.rdata = q.chout;
            end else if (bus_req.araddr == safety_io_pkg::OFS_OUTCFG) begin
                d.rdata = q.outcfg;
            end else if (bus_req.araddr == safety_io_pkg::OFS_DISC) begin
                d.rdata = q.disc;
            end else if (bus_req.araddr == safety_io_pkg::OFS_STATUS) begin
                d.rdata[5:0] = q.act;
                d.rdata[safety_io_pkg::ST_INH_POS +: 2] = q.inh;
                d.rdata[safety_io_pkg::ST_FLT_BIT] = |q.cause;
            end else if (bus_req.araddr == safety_io_pkg::OFS_FAULT) begin
                d.rdata[2:0] = q.cause;
            end else begin
                d.rresp = safety_io_pkg::RESP_SLVERR;
            end
        end

        // Quarter-period phase counter: A is the upper phase bit, B its gray neighbour.
        tick = (q.qcnt == safety_io_pkg::QUARTER_LAST);
        d.qcnt = tick ? '0 : q.qcnt + 10'h001;
        d.ph = tick ? q.ph + 2'h1 : q.ph;
        d.cyc = {d.ph[1] ^ d.ph[0], d.ph[1], d.ph[1] ^ d.ph[0], d.ph[1]};

        xf_in = 1'b0;
        rq = '0;
        inh = '0;
        for (int i = 0; i < safety_io_pkg::NUM_IN; i++) begin
            // A tested line may only be high while its own clock is high.
            if (tick && q.incfg[safety_io_pkg::TST_POS + i]) begin
                if (q.cyc[(i >= 3) ? 2 : 0]) begin
                    d.eva[i] = safe_in_a_n[i];
                end else if (safe_in_a_n[i]) begin
                    xf_in = 1'b1;
                end
                if (q.cyc[(i >= 3) ? 3 : 1]) begin
                    d.evb[i] = safe_in_b_n[i];
                end else if (safe_in_b_n[i]) begin
                    xf_in = 1'b1;
                end
            end
            if (q.incfg[safety_io_pkg::TST_POS + i]) begin
                raw = !q.eva[i] || !q.evb[i];
            end else begin
                raw = !safe_in_a_n[i] || !safe_in_b_n[i];
            end
            if (!raw) begin
                d.fcnt[i] = '0;
            end else if (q.fcnt[i] != safety_io_pkg::FILT_LAST) begin
                d.fcnt[i] = q.fcnt[i] + 8'h01;
            end
            // The filter trades a short activation delay for immunity to test pulses.
            d.act[i] = q.incfg[i] ? (raw && q.fcnt[i] == safety_io_pkg::FILT_LAST) : raw;
            ax = !single && (i >= 3);
            if (d.act[i]) begin
                rq[{ax, q.inmap[3*i +: 3]}] = 1'b1;
            end
        end
        for (int k = 0; k < 2; k++) begin
            ax = !single && (k == 1);
            if (!sto_in_a_n[k] || !sto_in_b_n[k]) begin
                rq[{ax, safety_io_pkg::STO_FN}] = 1'b1;
                inh[ax] = 1'b1;
            end
            if (q.chcfg[k] && (!chain_in_a_n[k] || !chain_in_b_n[k])) begin
                rq[{ax, q.chcfg[safety_io_pkg::CH_MAP_POS + 4*k +: 3]}] = 1'b1;
            end
        end
        if (single) begin
            inh[1] = 1'b1;
        end

        da = {chain_in_a_n, sto_in_a_n, safe_in_a_n};
        db = {chain_in_b_n, sto_in_b_n, safe_in_b_n};
        xd = 1'b0;
        for (int j = 0; j < safety_io_pkg::NUM_DUAL; j++) begin
            if (da[j] == db[j]) begin
                d.dcnt[j] = '0;
            end else if (q.dcnt[j] >= q.disc[15:0]) begin
                xd = 1'b1;
            end else begin
                d.dcnt[j] = q.dcnt[j] + 16'h0001;
            end
        end
        xo = (q.sout != out_fb);
        d.cause = (q.cause & ~clr) | {xo, xf_in, xd};
        flt = |d.cause;
        if (flt) begin
            rq = '1;
            inh = '1;
        end
        d.req = rq;
        d.inh = inh;
        d.pwm = pwm_in & ~{{6{inh[1]}}, {6{inh[0]}}};
        for (int k = 0; k < 2; k++) begin
            d.chn[k] = !(|(q.chout[8*k +: 8] & sfn_active[8*k +: 8]) || flt);
        end
        for (int j = 0; j < safety_io_pkg::NUM_OUT; j++) begin
            o = q.outcfg[8*j +: 8];
            ax = o[safety_io_pkg::OUT_AX_BIT] && !single;
            raw = sfn_active[{ax, o[2:0]}] || flt;
            d.sout[j] = o[safety_io_pkg::OUT_INV_BIT] ? !raw : raw;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.outcfg <= safety_io_pkg::RST_OUTCFG;
            q.disc <= safety_io_pkg::RST_DISC;
            q.req <= '1;
            q.inh <= '1;
            q.sout <= 4'hf;
        end else if (ce) begin
            q <= d;
        end
    end

    assign bus_rsp.awready = !q.awg && !q.bv;
    assign bus_rsp.wready = !q.wg && !q.bv;
    assign bus_rsp.bvalid = q.bv;
    assign bus_rsp.bresp = q.bresp;
    assign bus_rsp.arready = !q.rv;
    assign bus_rsp.rvalid = q.rv;
    assign bus_rsp.rdata = q.rdata;
    assign bus_rsp.rresp = q.rresp;
    assign chain_out_a_n = q.chn;
    assign chain_out_b_n = q.chn;
    assign safe_out = q.sout;
    assign cyc_out = q.cyc;
    assign sfn_request = q.req;
    assign pulse_inhibit = q.inh;
    assign pwm_out = q.pwm;
    assign fault = |q.cause;

    sequence s_step;
        ce ##1 1'b1;
    endsequence

    sequence s_in0_low;
        ce && !q.incfg[0] && !q.incfg[safety_io_pkg::TST_POS] && !safe_in_a_n[0] && !safe_in_b_n[0];
    endsequence

    AST_IN_LOWACT: assert property (@(posedge ref_clk) disable iff (rst)
        s_in0_low |=> sfn_request[{1'b0, $past(q.inmap[2:0])}])
        else $error("low safe input did not request its function");
    AST_STO_INH: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !sto_in_a_n[0]) |=> pulse_inhibit[0])
        else $error("torque off input did not set pulse inhibit");
    AST_PWM_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
        pulse_inhibit[1] |-> pwm_out[11:6] == 6'h00)
        else $error("switching pulses pass while inhibited");
    AST_CHAIN_OR: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && |(q.chout[7:0] & sfn_active[7:0])) |=> !chain_out_a_n[0] && !chain_out_b_n[0])
        else $error("chain output not at active level");
    AST_FAULT_SAFE: assert property (@(posedge ref_clk) disable iff (rst)
        fault |-> sfn_request == 16'hffff && pulse_inhibit == 2'h3)
        else $error("fault without safe state");
    AST_FAULT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (fault && !do_wr) |=> fault)
        else $error("fault dropped without software clear");
    AST_A_SAME: assert property (@(posedge ref_clk) disable iff (rst)
        cyc_out[0] == cyc_out[2] && cyc_out[1] == cyc_out[3])
        else $error("group test clocks out of phase");
    AST_QUARTER: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(cyc_out[0]) |-> $stable(cyc_out[1]))
        else $error("A and B test clocks switched together");
    AST_OUT_XF: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && safe_out != out_fb) |=> fault)
        else $error("output crossfault not flagged");
    AST_POLARITY: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && !flt && q.outcfg[7:0] == safety_io_pkg::RST_OUTCFG[7:0] && sfn_active[0]) |=> !safe_out[0])
        else $error("inverted safe output not low while its function is active");
    AST_B_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (bus_rsp.bvalid && !bus_req.bready) |=> bus_rsp.bvalid)
        else $error("write response withdrawn early");
    AST_DISC: assert property (@(posedge ref_clk) disable iff (rst)
        (ce && q.dcnt[0] >= q.disc[15:0] && safe_in_a_n[0] != safe_in_b_n[0]) |=> fault)
        else $error("discrepancy timeout not flagged");
endmodule : safety_io_interface

// >>> inc/safety_io_pkg.sv
// Shared constants and carrier types for the safety I/O interface.
package safety_io_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FILT_NS       = 2000;
    localparam int FILT_CYC      = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUARTER_NS    = 40000;
    localparam int QUARTER_CYC   = QUARTER_NS / CLK_PERIOD_NS;
    localparam logic [7:0] FILT_LAST    = 8'(FILT_CYC);
    localparam logic [9:0] QUARTER_LAST = 10'(QUARTER_CYC - 1);

    localparam int NUM_IN   = 6;
    localparam int NUM_DUAL = 10;
    localparam int NUM_OUT  = 4;
    localparam int FN_W     = 3;
    localparam logic [2:0] STO_FN = 3'h0;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_INCFG  = 8'h04;
    localparam logic [7:0] OFS_INMAP  = 8'h08;
    localparam logic [7:0] OFS_CHCFG  = 8'h0c;
    localparam logic [7:0] OFS_CHOUT  = 8'h10;
    localparam logic [7:0] OFS_OUTCFG = 8'h14;
    localparam logic [7:0] OFS_DISC   = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_FAULT  = 8'h20;

    localparam logic [31:0] MASK_CTRL   = 32'h0000_0001;
    localparam logic [31:0] MASK_INCFG  = 32'h0000_3f3f;
    localparam logic [31:0] MASK_INMAP  = 32'h0003_ffff;
    localparam logic [31:0] MASK_CHCFG  = 32'h0000_0773;
    localparam logic [31:0] MASK_CHOUT  = 32'h0000_ffff;
    localparam logic [31:0] MASK_OUTCFG = 32'h1f1f_1f1f;
    localparam logic [31:0] MASK_DISC   = 32'h0000_ffff;
    localparam logic [31:0] MASK_FAULT  = 32'h0000_0007;
    localparam logic [31:0] RST_OUTCFG  = 32'h1010_1010;
    localparam logic [31:0] RST_DISC    = 32'h0000_00fa;

    localparam int SINGLE_BIT = 0;
    localparam int TST_POS    = 8;
    localparam int CH_MAP_POS = 4;
    localparam int OUT_AX_BIT = 3;
    localparam int OUT_INV_BIT = 4;
    localparam int ST_INH_POS = 8;
    localparam int ST_FLT_BIT = 16;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
endpackage : safety_io_pkg
